//--- inc/sensor_seq_pkg.sv
package sensor_seq_pkg;

    // register map
    localparam logic [15:0] MODE_CTRL_ADDR = 16'h301A;
    localparam logic [15:0] MODE_CTRL_RST  = 16'h0000;
    localparam int          STREAM_BIT     = 2;
    localparam int          STOP_MODE_BIT  = 3;

    // timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int INIT_EXTCLKS    = 150000;
    localparam int HARD_RESET_MS   = 1;
    localparam int HARD_RESET_CYC  = (HARD_RESET_MS * CLK_HZ + 999) / 1000;
    localparam int INIT_CNT_W      = 18;

    typedef enum logic [2:0] {
        ST_RESET   = 3'b000,
        ST_INIT    = 3'b001,
        ST_STANDBY = 3'b010,
        ST_STREAM  = 3'b011,
        ST_DRAIN   = 3'b100
    } seq_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        row_end;
        logic        frame_end;
    } video_mark_s;

endpackage

//--- design/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic s1_r;
    logic s1_nxt;
    logic s2_nxt;

    always_comb begin
        s1_nxt = srst_in ? 1'b0 : d_in;
        s2_nxt = srst_in ? 1'b0 : s1_r;
    end

    always_ff @(posedge clk_in) begin
        s1_r  <= s1_nxt;
        q_out <= s2_nxt;
    end
endmodule
`default_nettype wire

//--- design/sensor_power_reset_sequencer.sv
// Operation
// (R1) host turns supplies on PLL, analog/pixel, IO, core, serial; ~100 us apart
// (R2) host never enables PLL supply after any other supply
// (R3) host starts input clock only after last supply is stable
// (R4) host holds active-low reset at least 1 ms after supplies settle
// (R5) parallel outputs stay high-impedance while hard reset is asserted; code drops par_oe_out two clocks after the pin falls
// (R6) init of 150000 input clocks into standby; host waits before configuring
// (R7) host waits 1 ms for PLL lock before enabling streaming
// (R8) writing 1 to bit 2 of mode control register starts streaming
// (R9) host clears streaming bit before removing any supply
// (R10) after streaming clears, standby only at end of row or frame
// (R11) host removes supplies serial, core, IO, analog/pixel, PLL last
// (R12) host waits 100 ms between power-down and next power-up
// (R13) RC-held reset must also span supply and crystal settling, ~30 ms
// (R14) init count starts at reset release; config writes ignored until done
`timescale 1ns/1ps
`default_nettype none
module sensor_power_reset_sequencer (
    // clock and reset (clk_in is the external input clock)
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    // hard reset pin, active low
    input  wire logic                        hard_reset_n_in,
    // register access from the serial interface
    input  wire sensor_seq_pkg::reg_req_s    req_in,
    output logic      [15:0]                 rdata_out,
    output logic                             rvalid_out,
    // video timing marks from the readout
    input  wire sensor_seq_pkg::video_mark_s mark_in,
    // status and output control
    output logic                             par_oe_out,
    output logic                             streaming_out,
    output logic                             standby_out,
    output logic                             init_done_out
);
    import sensor_seq_pkg::*;

    logic                  rst_n_sync;
    seq_state_e            state_r;
    seq_state_e            state_nxt;
    logic [INIT_CNT_W-1:0] init_cnt_r;
    logic [INIT_CNT_W-1:0] init_cnt_nxt;
    logic [15:0]           ctrl_r;
    logic [15:0]           ctrl_nxt;
    logic [15:0]           rdata_nxt;
    logic                  rvalid_nxt;
    logic                  cfg_ok;
    logic                  wr_ctrl;
    logic                  end_mark;

    sync2 u_rst_sync (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .d_in    (hard_reset_n_in),
        .q_out   (rst_n_sync)
    );

    assign cfg_ok   = (state_r != ST_RESET) && (state_r != ST_INIT);
    assign wr_ctrl  = req_in.wr && cfg_ok && (req_in.addr == MODE_CTRL_ADDR); // [R14]
    // stop point chosen by config bit: frame end when set, row end otherwise
    assign end_mark = ctrl_r[STOP_MODE_BIT] ? mark_in.frame_end : mark_in.row_end;

    always_comb begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        ctrl_nxt     = wr_ctrl ? req_in.wdata : ctrl_r;
        rvalid_nxt   = req_in.rd;
        rdata_nxt    = 16'h0000;
        if (req_in.rd && req_in.addr == MODE_CTRL_ADDR) begin
            rdata_nxt = ctrl_r;
        end
        unique case (state_r)
            ST_RESET: begin
                init_cnt_nxt = '0;
                if (rst_n_sync) begin
                    state_nxt = ST_INIT; // [R14]
                end
            end
            ST_INIT: begin
                init_cnt_nxt = init_cnt_r + 1'b1;
                if (init_cnt_r == INIT_CNT_W'(INIT_EXTCLKS - 1)) begin
                    state_nxt = ST_STANDBY; // [R6]
                end
            end
            ST_STANDBY: begin
                if (ctrl_r[STREAM_BIT]) begin
                    state_nxt = ST_STREAM; // [R8]
                end
            end
            ST_STREAM: begin
                if (!ctrl_r[STREAM_BIT]) begin
                    state_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (ctrl_r[STREAM_BIT]) begin
                    state_nxt = ST_STREAM;
                end else if (end_mark) begin
                    state_nxt = ST_STANDBY; // [R10]
                end
            end
            default: state_nxt = ST_RESET;
        endcase
        if (!rst_n_sync) begin
            state_nxt    = ST_RESET;
            init_cnt_nxt = '0;
            ctrl_nxt     = MODE_CTRL_RST;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r    <= ST_RESET;
            init_cnt_r <= '0;
            ctrl_r     <= MODE_CTRL_RST;
            rdata_out  <= 16'h0000;
            rvalid_out <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            ctrl_r     <= ctrl_nxt;
            rdata_out  <= rdata_nxt;
            rvalid_out <= rvalid_nxt;
        end
    end

    // outputs driven only while streaming or draining the current row/frame
    assign par_oe_out    = rst_n_sync && (state_r == ST_STREAM || state_r == ST_DRAIN); // [R5]
    assign streaming_out = (state_r == ST_STREAM) || (state_r == ST_DRAIN);
    assign standby_out   = (state_r == ST_STANDBY);
    assign init_done_out = cfg_ok;
endmodule
`default_nettype wire

//--- test/seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module seq_asserts import sensor_seq_pkg::*; (
    input wire logic clk_in, srst_in, hard_reset_n_in,
    input wire reg_req_s req_in,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out, par_oe_out, streaming_out, standby_out, init_done_out,
    input wire video_mark_s mark_in
);
    int unsigned up_r;
    always_ff @(posedge clk_in) up_r <= (srst_in || !hard_reset_n_in) ? 0 : up_r + 1;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_hiz_in_reset: assert property (!hard_reset_n_in [*4] |-> !par_oe_out)
        else $error("output driven in reset");
    a_init_length: assert property ($rose(init_done_out) |-> up_r >= INIT_EXTCLKS)
        else $error("init too short");
    a_init_gates_cfg: assert property (!init_done_out |-> !streaming_out)
        else $error("stream before init");
    a_stream_start: assert property (req_in.wr && req_in.addr == MODE_CTRL_ADDR
        && req_in.wdata[STREAM_BIT] && init_done_out |-> ##2 streaming_out)
        else $error("stream not started");
    a_stop_at_mark: assert property ($rose(standby_out) && $past(streaming_out)
        |-> $past(mark_in.row_end || mark_in.frame_end))
        else $error("standby mid row");
    c_stream: cover property ($rose(streaming_out));
    c_stop: cover property ($rose(standby_out) && $past(streaming_out));
    c_read: cover property (rvalid_out);
endmodule
bind sensor_power_reset_sequencer seq_asserts seq_asserts_inst (.clk_in(clk_in),
    .srst_in(srst_in), .hard_reset_n_in(hard_reset_n_in), .req_in(req_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .par_oe_out(par_oe_out),
    .streaming_out(streaming_out), .standby_out(standby_out),
    .init_done_out(init_done_out), .mark_in(mark_in));
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_in,
    input wire logic srst_in,
    output logic hard_reset_n_out
);
    int cnt = 0;
    initial hard_reset_n_out = 1'b0;
    // reset held low 1 ms past settling
    always @(posedge clk_in) begin
        cnt <= srst_in ? 0 : cnt + 1;
        hard_reset_n_out <= !srst_in && cnt >= 10000;
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sensor_seq_pkg::*;
    logic clk_in = 1'b0, srst_in = 1'b1, hrst_n, rv, oe, strm, stby, done;
    reg_req_s req = '0;
    video_mark_s mk = '0;
    logic [15:0] rdat;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    host_model host_model_inst (.clk_in(clk_in), .srst_in(srst_in), .hard_reset_n_out(hrst_n));
    sensor_power_reset_sequencer sensor_power_reset_sequencer_inst (.clk_in(clk_in),
        .srst_in(srst_in), .hard_reset_n_in(hrst_n), .req_in(req), .rdata_out(rdat),
        .rvalid_out(rv), .mark_in(mk), .par_oe_out(oe), .streaming_out(strm),
        .standby_out(stby), .init_done_out(done));
    initial forever #50 clk_in = ~clk_in;
    task automatic step(input int n); repeat (n) @(posedge clk_in); #1; endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req = '{1'b1, 1'b0, a, d}; step(1); req = '0; step(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        req = '{1'b0, 1'b1, a, 16'h0000}; step(1); req = '0;
        chk(16'(rv), 16'h0001); chk(rdat, e); step(1);
    endtask
    task automatic mark(input logic r, input logic f);
        mk = '{r, f}; step(1); mk = '0; step(1);
    endtask
    task final_report;
        $display("checks=%0d errors=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 200000) begin error_cnt++; final_report; end
    end
    initial begin
        step(10); srst_in = 1'b0; step(5);
        chk(16'(oe), 16'h0000);
        while (hrst_n !== 1'b1) step(1);
        step(10); wr(MODE_CTRL_ADDR, 16'h0004);
        chk(16'(strm), 16'h0000);
        $display("T1 done");
        while (done !== 1'b1) step(1);
        chk(16'(stby), 16'h0001);
        chk(16'(done), 16'h0001);
        rd(MODE_CTRL_ADDR, 16'h0000);
        rd(16'h3018, 16'h0000);
        $display("T2 done");
        step(10000); wr(MODE_CTRL_ADDR, 16'h0004);
        chk({strm, oe}, 16'h0003);
        rd(MODE_CTRL_ADDR, 16'h0004);
        $display("T3 done");
        wr(MODE_CTRL_ADDR, 16'h0000); step(3);
        chk({strm, stby}, 16'h0002);
        mark(1'b1, 1'b0); chk({strm, stby, oe}, 16'h0002);
        $display("T4 done");
        wr(MODE_CTRL_ADDR, 16'h000C); wr(MODE_CTRL_ADDR, 16'h0008);
        mark(1'b1, 1'b0); chk({strm, stby}, 16'h0002);
        mark(1'b0, 1'b1); chk({strm, stby}, 16'h0001);
        $display("T5 done");
        final_report;
    end
endmodule
`default_nettype wire
